// ### pmr_delay.sv
/*
  Down counter that times the start-up and wake delays.
  Assumes run_i stays high for the whole delay and drops between two delays.
*/
`timescale 1ns/10ps

module pmr_delay #(
  parameter int COUNT = 1024,
  localparam int W    = $clog2(COUNT)
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic run_i,
  output logic      done_o
);

  logic [W-1:0] cnt;

  // Reloaded while idle, so each delay starts full length
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt <= W'(COUNT - 1);
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  assign done_o = run_i && (cnt == '0);

endmodule

// ### pmr_host_model.sv
/*
  Host model: classic Wishbone master and driver of the reset/power-down pin.
  Assumes the slave answers on clk_i; the bench calls xfer and pin.
*/
`timescale 1ns/10ps

module pmr_host_model (
  // Clock
  input  wire logic        clk_i,
  // Wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic      [9:0]  wb_adr_o,
  output logic      [3:0]  wb_sel_o,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  // Pin and status
  output logic             reset_sleep_request_bit_n_o,
  output logic             timeout_o
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 10'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
    reset_sleep_request_bit_n_o = 1'b1;
    timeout_o = 1'b0;
  end

  // Bounded wait: start-up and hard power-down hold requests for 1024+ cycles
  task automatic xfer(input logic we, input logic [9:0] adr, input logic [7:0] dat,
                      output logic [31:0] rdat, output int waited);
    waited = 0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h0, dat};
    do begin
      @(posedge clk_i);
      waited++;
    end while (wb_ack_i !== 1'b1 && waited < 3000);
    if (wb_ack_i !== 1'b1)
      timeout_o <= 1'b1;
    rdat = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released we, address and data lines show no stale value; sel keeps its value
    wb_we_o <= ~we;
    wb_adr_o <= ~adr;
    wb_dat_o <= ~wb_dat_o;
  endtask

  task automatic pin(input logic v);
    @(posedge clk_i);
    reset_sleep_request_bit_n_o <= v;
  endtask
endmodule

// ### pmr_params.svh
/*
  Constants of the power-mode and reset controller: register indices, field
  positions, reset values and timing counts.
  Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices, byte address is four times the index
`define PMR_IDX_RESERVED0     8'h00
`define PMR_IDX_COMMAND       8'h01
`define PMR_IDX_ANTENNA       8'h14
`define PMR_IDX_STATUS        8'h30
`define PMR_IDX_CMDCTL        8'h31

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define PMR_CMD_FIELD_LSB     0
`define PMR_CMD_FIELD_W       4
`define PMR_CMD_SLEEP_BIT     4
`define PMR_ANT_EN1_BIT       0
`define PMR_ANT_EN2_BIT       1
`define PMR_CMDCTL_FINISH_BIT 0
`define PMR_STAT_SLEEP_BIT    0
`define PMR_STAT_WAKE_BIT     1
`define PMR_STAT_TXPD_BIT     2
`define PMR_STAT_READY_BIT    3

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define PMR_CMD_IDLE          4'h0
`define PMR_ANT_RESET         2'h0

////////////////////////////////////////////////////////////////////////////////
// Timing
`define PMR_CLK_PERIOD_NS     10
`define PMR_SPIKE_NS          10
`define PMR_SPIKE_CYC         ((`PMR_SPIKE_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS)
`define PMR_FILTER_CYC        (`PMR_SPIKE_CYC + 1)
`define PMR_RESET_MIN_NS      100
`define PMR_RESET_MIN_CYC     ((`PMR_RESET_MIN_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS)
`define PMR_STARTUP_CYC       1024
`define PMR_WAKE_CYC          1024

`endif

// ### pmr_pin_filter.sv
/*
  Synchroniser and spike filter for the active-low reset/power-down pin.
  Assumes the pin is asynchronous to clk_i and that a real reset holds the pin
  low for much longer than the filter window.
*/
`timescale 1ns/10ps
`include "pmr_params.svh"

module pmr_pin_filter #(
  parameter int FILTER_CYC = `PMR_FILTER_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin side
  input  wire logic pin_n_i,
  // Filtered result
  output logic      pd_active_o
);

  logic       sync1;
  logic       sync2;
  logic       level_n;
  logic [3:0] run_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= pin_n_i;
      sync2 <= sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Level only flips after FILTER_CYC equal samples, so one-sample spikes die
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_n <= 1'b1;
      run_cnt <= 4'h0;
    end else if (sync2 != level_n) begin
      if (run_cnt == 4'(FILTER_CYC - 1)) begin // RL11
        level_n <= sync2;
        run_cnt <= 4'h0;
      end else begin
        run_cnt <= run_cnt + 4'h1;
      end
    end else begin
      run_cnt <= 4'h0;
    end
  end

  assign pd_active_o = ~level_n;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence low_pair;
    (!sync2 && !pd_active_o) [*2];
  endsequence

  spike_reject_a: assert property ($rose(pd_active_o) |-> $past(!sync2, 1) && $past(!sync2, 2)) // RL11
    else $error("power-down taken from a short spike");
  filter_commit_a: assert property (low_pair |=> pd_active_o) // RL11
    else $error("steady low pin not taken as power-down");

endmodule

// ### pmr_pkg.sv
/*
  Types of the power-mode and reset controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pmr_pkg;

  typedef enum logic [4:0] {
    ST_STARTUP = 5'b00001,
    ST_RUN     = 5'b00010,
    ST_SLEEP   = 5'b00100,
    ST_WAKE    = 5'b01000,
    ST_HARD    = 5'b10000
  } pmr_state_t;

  typedef struct packed {
    logic        osc_enable;
    logic        sinks_enable;
    logic        input_clamp;
  } pmr_power_t;

  typedef struct packed {
    logic [3:0]  command;
    logic        sleep;
  } pmr_cmd_t;

endpackage

// ### pmr_tb_top.sv
/*
  Self-checking bench of pmr_top: reads queue their expected data, a monitor
  compares at each read's ack. Assumes pmr_host_model as bus master and pin driver.
*/
`timescale 1ns/10ps
`include "pmr_params.svh"

module pmr_tb_top;
  localparam logic [9:0] A_RES  = {`PMR_IDX_RESERVED0, 2'b00};
  localparam logic [9:0] A_CMD  = {`PMR_IDX_COMMAND, 2'b00};
  localparam logic [9:0] A_ANT  = {`PMR_IDX_ANTENNA, 2'b00};
  localparam logic [9:0] A_STAT = {`PMR_IDX_STATUS, 2'b00};
  localparam logic [9:0] A_CTL  = {`PMR_IDX_CMDCTL, 2'b00};
  logic        clk_i;
  logic        rst_i;
  logic        cyc, stb, we, ack, pin_n, tmo;
  logic        osc, sinks, clamp, ant, ready;
  logic [9:0]  adr;
  logic [3:0]  sel, command, c;
  logic [31:0] dat_w, dat_r, rdat, seed, r;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int          mismatches, tests_run, waited;
  time         t0;

  pmr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .reset_sleep_request_bit_n_i(pin_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .osc_enable_o(osc), .sinks_enable_o(sinks),
    .input_clamp_o(clamp), .antenna_drive_o(ant), .device_ready_o(ready), .command_o(command));
  pmr_host_model u_host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat_w), .wb_ack_i(ack), .wb_dat_i(dat_r),
    .reset_sleep_request_bit_n_o(pin_n), .timeout_o(tmo));

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [4:0] exp);
    chk({27'h0, osc, sinks, clamp, ant, ready}, {27'h0, exp});
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    exp_q.push_back({1'b0, 32'h0});
    u_host.xfer(1'b1, a, d, rdat, waited);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] d);
    exp_q.push_back({1'b1, 24'h0, d});
    u_host.xfer(1'b0, a, 8'h00, rdat, waited);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Monitor: every ack retires the oldest note
  always @(posedge clk_i) begin
    if (ack === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32])
        chk(dat_r, e[31:0]);
    end
  end

  always @(posedge tmo) begin
    mismatches++;
    end_of_test();
  end

  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end

  ////////////////////////////////////////
  initial begin
    seed = 32'h000121C2;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk_out(5'b11000);
    rd(A_RES, 8'h00);
    chk(32'(waited >= 1024), 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(A_ANT, {6'h00, i[1:0]});
      rd(A_ANT, {6'h00, i[1:0]});
      rd(A_STAT, {4'h0, 1'b1, ~&i[1:0], 2'b00});
      chk({31'h0, ant}, {31'h0, &i[1:0]});
    end
    r = xs();
    wr(A_STAT, r[7:0]);
    rd(A_STAT, 8'h08);
    r = xs();
    c = r[3:0] | 4'h1;
    wr(A_CMD, {4'h0, c});
    rd(A_CMD, {4'h0, c});
    chk({28'h0, command}, {28'h0, c});
    wr(A_CTL, 8'h01);
    rd(A_CTL, 8'h00);
    rd(A_CMD, 8'h00);
    rd(A_ANT, 8'h03);
    wr(A_RES, 8'h00);
    rd(A_RES, 8'h00);
    rd(10'h008, 8'h00);
    rd(A_CMD | 10'h001, 8'h00);
    // Soft power-down, then a change that must stay hidden until the wake delay ends
    wr(A_CMD, 8'h15);
    chk_out(5'b00011);
    rd(A_CMD, 8'h15);
    rd(A_ANT, 8'h03);
    rd(A_STAT, 8'h01);
    wr(A_ANT, 8'h00);
    chk_out(5'b00011);
    wr(A_CMD, 8'h05);
    t0 = $time;
    rd(A_CMD, 8'h15);
    // Ready stays frozen through sleep; the antenna drop marks the exit
    for (int i = 0; i < 2000 && ant !== 1'b0; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(32'(($time - 1 - t0) / 10), 32'd1023);
    rd(A_CMD, 8'h05);
    rd(A_STAT, 8'h0C);
    chk({31'h0, ant}, 32'h0);
    // Pin: one-sample spike, then a real hard power-down
    wr(A_ANT, 8'h03);
    wr(A_CMD, 8'h07);
    u_host.pin(1'b0);
    u_host.pin(1'b1);
    repeat (8) @(posedge clk_i);
    #1 chk_out(5'b11011);
    rd(A_CMD, 8'h07);
    u_host.pin(1'b0);
    // Low for longer than the minimum reset pulse
    repeat (`PMR_RESET_MIN_CYC) @(posedge clk_i);
    #1 chk_out(5'b00111);
    chk({28'h0, command}, 32'h7);
    u_host.pin(1'b1);
    wr(10'h008, 8'h55);
    chk(32'(waited >= 1024), 32'h1);
    rd(A_RES, 8'h00);
    rd(A_ANT, 8'h00);
    rd(A_CMD, 8'h00);
    end_of_test();
  end
endmodule

// ### pmr_top.sv
/*
  Power-mode and reset controller: hard power-down from the reset pin, soft
  power-down from the command register, transmitter power-down from the
  antenna driver enables, start-up delay, and the Wishbone register slave.
  Assumes a classic Wishbone master on clk_i and an asynchronous pin.
*/
// How it works
// RL1 - Pin low: hard power-down, oscillator and sinks off
// RL2 - Hard power-down clamps inputs, freezes outputs
// RL3 - Sleep bit set: soft power-down at once
// RL4 - Soft power-down: inputs work, outputs frozen
// RL5 - Soft power-down keeps all register contents
// RL6 - Sleep clear waits 1024 cycles, bit stays set
// RL7 - Device clears sleep bit on real exit
// RL8 - UART host first sends 55h after wake
// RL9 - Host polls address 0 until ready
// RL10 - Either antenna enable low: drivers off
// RL11 - Reset pulses under 10 ns are ignored
// RL12 - Host holds reset low at least 100 ns
// RL13 - 1024-cycle delay before host accesses accepted
// RL14 - Read/write bits never changed internally
// RL15 - Dynamic bits written by host and hardware
// RL16 - Read-only bits show internal state only
// RL17 - Write-only bits always read as zero
// RL18 - Host leaves reserved registers, writes zero
// RL19 - Host leaves test bits unchanged
// RL20 - Command register sits at index 01h
// RL21 - Pin release restarts from reset, then delay
`timescale 1ns/10ps
`include "pmr_params.svh"

module pmr_top #(
  parameter int STARTUP_CYC = `PMR_STARTUP_CYC,
  parameter int WAKE_CYC    = `PMR_WAKE_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Reset/power-down pin
  input  wire logic        reset_sleep_request_bit_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Power controls
  output logic             osc_enable_o,
  output logic             sinks_enable_o,
  output logic             input_clamp_o,
  // Device pins and status
  output logic             antenna_drive_o,
  output logic             device_ready_o,
  output logic      [3:0]  command_o
);

  pmr_pkg::pmr_state_t state;
  pmr_pkg::pmr_state_t next_state;
  pmr_pkg::pmr_cmd_t   cmd_reg;
  pmr_pkg::pmr_power_t power;
  pmr_pkg::pmr_power_t next_power;
  logic [1:0]          antenna_driver_control;
  logic                pd_active;
  logic                delay_run;
  logic                delay_done;
  logic                start_done;
  logic                wake_done;
  logic                accepting;
  logic                req_take;
  logic                wr_take;
  logic [7:0]          idx;
  logic                wr_cmd;
  logic                wr_ant;
  logic                finish_take;
  logic                sleep_set;
  logic                sleep_clr;
  logic                reg_clr;
  logic                tx_pd;
  logic [31:0]         next_rdata;
  logic [10:0]         phase_cnt;

  function automatic logic reg_hit(input logic [9:0] adr, input logic [7:0] target);
    reg_hit = (adr[9:2] == target) && (adr[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin filter and delay timers
  pmr_pin_filter u_filter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .pin_n_i     (reset_sleep_request_bit_n_i),
    .pd_active_o (pd_active)
  );

  // Start-up and wake never overlap, but lengths may differ
  pmr_delay #(.COUNT(STARTUP_CYC)) u_start (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (state == pmr_pkg::ST_STARTUP),
    .done_o (start_done)
  );

  pmr_delay #(.COUNT(WAKE_CYC)) u_wake (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (state == pmr_pkg::ST_WAKE),
    .done_o (wake_done)
  );

  assign delay_run  = (state == pmr_pkg::ST_STARTUP) || (state == pmr_pkg::ST_WAKE);
  assign delay_done = delay_run && (start_done || wake_done);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // No answer while starting or in hard power-down; the master simply waits
  assign accepting   = (state == pmr_pkg::ST_RUN) || (state == pmr_pkg::ST_SLEEP) ||
                       (state == pmr_pkg::ST_WAKE); // RL13
  assign req_take    = wb_cyc_i && wb_stb_i && !wb_ack_o && accepting && !pd_active;
  assign wr_take     = req_take && wb_we_i && wb_sel_i[0];
  assign idx         = wb_adr_i[9:2];
  assign wr_cmd      = wr_take && reg_hit(wb_adr_i, `PMR_IDX_COMMAND); // RL20
  assign wr_ant      = wr_take && reg_hit(wb_adr_i, `PMR_IDX_ANTENNA);
  assign finish_take = wr_take && reg_hit(wb_adr_i, `PMR_IDX_CMDCTL) && wb_dat_i[`PMR_CMDCTL_FINISH_BIT];
  assign sleep_set   = wr_cmd && wb_dat_i[`PMR_CMD_SLEEP_BIT];
  assign sleep_clr   = wr_cmd && !wb_dat_i[`PMR_CMD_SLEEP_BIT];
  assign reg_clr     = rst_i || (state == pmr_pkg::ST_HARD); // RL21 RL5
  assign tx_pd       = !(antenna_driver_control[`PMR_ANT_EN1_BIT] && antenna_driver_control[`PMR_ANT_EN2_BIT]);

  ////////////////////////////////////////////////////////////////////////////////
  // Power state machine
  always_comb begin
    next_state = state;
    if (pd_active) begin
      next_state = pmr_pkg::ST_HARD; // RL1
    end else begin
      case (state)
        pmr_pkg::ST_HARD: next_state = pmr_pkg::ST_STARTUP; // RL21
        pmr_pkg::ST_STARTUP: begin
          if (delay_done) begin
            next_state = pmr_pkg::ST_RUN; // RL13
          end
        end
        pmr_pkg::ST_RUN: begin
          if (sleep_set) begin
            next_state = pmr_pkg::ST_SLEEP; // RL3
          end
        end
        pmr_pkg::ST_SLEEP: begin
          if (sleep_clr) begin
            next_state = pmr_pkg::ST_WAKE; // RL6
          end
        end
        pmr_pkg::ST_WAKE: begin
          if (sleep_set) begin
            next_state = pmr_pkg::ST_SLEEP;
          end else if (delay_done) begin
            next_state = pmr_pkg::ST_RUN; // RL6
          end
        end
        default: next_state = pmr_pkg::ST_STARTUP;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= pmr_pkg::ST_STARTUP;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command register: dynamic command field and sleep bit
  always_ff @(posedge clk_i) begin
    if (reg_clr) begin
      cmd_reg.command <= `PMR_CMD_IDLE;
    end else if (wr_cmd) begin
      cmd_reg.command <= wb_dat_i[`PMR_CMD_FIELD_LSB +: `PMR_CMD_FIELD_W]; // RL15
    end else if (finish_take) begin
      cmd_reg.command <= `PMR_CMD_IDLE; // RL15
    end
  end

  // A host write of 0 never clears the bit; a host set beats the exit clear
  always_ff @(posedge clk_i) begin
    if (reg_clr) begin
      cmd_reg.sleep <= 1'b0;
    end else if (sleep_set) begin
      cmd_reg.sleep <= 1'b1; // RL3
    end else if (state == pmr_pkg::ST_WAKE && delay_done) begin
      cmd_reg.sleep <= 1'b0; // RL7
    end
  end

  // Host-only control bits, kept through soft power-down
  always_ff @(posedge clk_i) begin
    if (reg_clr) begin
      antenna_driver_control <= `PMR_ANT_RESET;
    end else if (wr_ant) begin
      antenna_driver_control <= wb_dat_i[1:0]; // RL14
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge
  always_comb begin
    next_rdata = 32'h0;
    if (reg_hit(wb_adr_i, `PMR_IDX_COMMAND)) begin
      next_rdata[`PMR_CMD_FIELD_LSB +: `PMR_CMD_FIELD_W] = cmd_reg.command;
      next_rdata[`PMR_CMD_SLEEP_BIT] = cmd_reg.sleep; // RL6
    end else if (reg_hit(wb_adr_i, `PMR_IDX_ANTENNA)) begin
      next_rdata[1:0] = antenna_driver_control;
    end else if (reg_hit(wb_adr_i, `PMR_IDX_STATUS)) begin
      next_rdata[`PMR_STAT_SLEEP_BIT] = (state == pmr_pkg::ST_SLEEP); // RL16
      next_rdata[`PMR_STAT_WAKE_BIT]  = (state == pmr_pkg::ST_WAKE);
      next_rdata[`PMR_STAT_TXPD_BIT]  = tx_pd;
      next_rdata[`PMR_STAT_READY_BIT] = (state == pmr_pkg::ST_RUN);
    end else begin
      next_rdata = 32'h0; // RL17
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req_take;
      if (req_take && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power controls follow the next state so they line up with it
  always_comb begin
    next_power.osc_enable   = !(next_state == pmr_pkg::ST_HARD || next_state == pmr_pkg::ST_SLEEP); // RL1 RL3
    next_power.sinks_enable = next_power.osc_enable;
    next_power.input_clamp  = (next_state == pmr_pkg::ST_HARD); // RL2
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power <= '{osc_enable: 1'b1, sinks_enable: 1'b1, input_clamp: 1'b0};
    end else begin
      power <= next_power;
    end
  end

  assign osc_enable_o   = power.osc_enable;
  assign sinks_enable_o = power.sinks_enable;
  assign input_clamp_o  = power.input_clamp;

  // Pins hold through any power-down and through the wake delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      antenna_drive_o <= 1'b0;
      device_ready_o  <= 1'b0;
      command_o       <= `PMR_CMD_IDLE;
    end else if (next_state == pmr_pkg::ST_RUN || next_state == pmr_pkg::ST_STARTUP) begin // RL2 RL4
      antenna_drive_o <= (next_state == pmr_pkg::ST_RUN) && !tx_pd; // RL10
      device_ready_o  <= (next_state == pmr_pkg::ST_RUN);
      command_o       <= cmd_reg.command;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge clk_i) begin
    if (rst_i || next_state != state) begin
      phase_cnt <= 11'h000;
    end else if (phase_cnt != 11'h7FF) begin
      phase_cnt <= phase_cnt + 11'h001;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence sleep_request;
    state == pmr_pkg::ST_RUN && sleep_set && !pd_active;
  endsequence

  sequence wake_end;
    state == pmr_pkg::ST_WAKE && delay_done && !sleep_set && !pd_active;
  endsequence

  hard_entry_a: assert property (pd_active |=> state == pmr_pkg::ST_HARD && !sinks_enable_o && !osc_enable_o) // RL1
    else $error("pin low did not power down");
  hard_freeze_a: assert property (state == pmr_pkg::ST_HARD |-> input_clamp_o && $stable(antenna_drive_o) &&
                                  $stable(device_ready_o) && $stable(command_o)) // RL2
    else $error("outputs moved in hard power-down");
  sleep_entry_a: assert property (sleep_request |=> state == pmr_pkg::ST_SLEEP && !osc_enable_o && cmd_reg.sleep) // RL3
    else $error("sleep request not taken at once");
  sleep_freeze_a: assert property (state == pmr_pkg::ST_SLEEP |-> $stable(antenna_drive_o) &&
                                   $stable(device_ready_o) && $stable(command_o)) // RL4
    else $error("outputs moved in soft power-down");
  sleep_retain_a: assert property ((state == pmr_pkg::ST_SLEEP && !wr_cmd && !wr_ant && !finish_take && !pd_active)
                                   |=> $stable(cmd_reg) && $stable(antenna_driver_control)) // RL5
    else $error("register lost in soft power-down");
  wake_hold_a: assert property (state == pmr_pkg::ST_WAKE |-> cmd_reg.sleep && osc_enable_o) // RL6
    else $error("sleep bit dropped before exit");
  wake_delay_a: assert property ((state == pmr_pkg::ST_WAKE && delay_done) |-> phase_cnt == 11'(WAKE_CYC - 1)) // RL6
    else $error("wake delay is not 1024 cycles");
  wake_clear_a: assert property (wake_end |=> state == pmr_pkg::ST_RUN && !cmd_reg.sleep ##1 device_ready_o) // RL7
    else $error("sleep bit not cleared on exit");
  tx_sleep_request_bit_a: assert property ((state == pmr_pkg::ST_RUN && tx_pd && !sleep_set && !pd_active)
                                   |=> !antenna_drive_o) // RL10
    else $error("antenna driven with an enable low");
  startup_delay_a: assert property ((state == pmr_pkg::ST_STARTUP && delay_done && !pd_active)
                                    |-> phase_cnt == 11'(STARTUP_CYC - 1) ##1 state == pmr_pkg::ST_RUN) // RL13
    else $error("start-up delay is not 1024 cycles");
  startup_accept_a: assert property ($rose(wb_ack_o) |-> $past(state) != pmr_pkg::ST_STARTUP &&
                                     $past(state) != pmr_pkg::ST_HARD) // RL13
    else $error("access answered before ready");
  release_restart_a: assert property ((state == pmr_pkg::ST_HARD && !pd_active) |=>
                                      state == pmr_pkg::ST_STARTUP && antenna_driver_control == `PMR_ANT_RESET) // RL21
    else $error("pin release did not restart");
  rw_bits_a: assert property ($changed(antenna_driver_control) |-> $past(wr_ant) ||
                              $past(state) == pmr_pkg::ST_HARD) // RL14
    else $error("control bits changed internally");
  cmd_return_a: assert property (finish_take |=> cmd_reg.command == `PMR_CMD_IDLE) // RL15
    else $error("command field did not return to idle");
  wo_read_a: assert property ((req_take && !wb_we_i && idx == `PMR_IDX_CMDCTL) |=> wb_ack_o && wb_dat_o == 32'h0) // RL17
    else $error("write-only register read nonzero");

endmodule
